// ===== core/rsd_top.sv
// Purpose: Comfort, standby and night setpoints, absolute or derived
// Assumes: All inputs on ref_clk; temperatures in 0.1 degC
// Notes: Outputs other than base_obj_present and shift_avail are registered one cycle after their cause, setpoints two cycles after a write

// What this block does
// - Two schemes: independent absolute targets or derived from one reference.
// - Frost and heat protection come only from configuration, writes refused.
// - Derived standby/night from reference by mode-chosen offsets, deadband when combined.
// - Programming with overwrite loads the reference from the configured after-reset value.
// - Reference write in derived mode updates every dependent target at once.
// - Reference object exists only when bus adjustment is enabled.
// - Received reference is rounded to 0.1 K or 0.5 K step.
// - Absolute targets accepted from 7.0 to 40.0 degC, no ordering enforced.
// - Absolute mode: active-mode telegram sets target of active mode, heat/cool apart.
// - Absolute mode: no reference, no deadband, changeover only by bus object.
// - Absolute mode offers no target shifting.
// - Programming with overwrite loads configured targets; without, stored ones kept.
// - Heating: standby and night are comfort minus reductions, comfort equals reference except with symmetrical deadband in combined mode.
// - Frost target defaults to 7 degC, selectable 7.0 to 40.0 degC.
// - Heating targets lie in 7.0 to 99.9 degC and not below frost.
// - Two-level heating: additional-level target is basic target minus level offset.
// - Cooling: standby and night are comfort plus increases.
// - Symmetrical deadband: comfort heat/cool are reference minus/plus half deadband.
// - Asymmetrical deadband: heat comfort is reference, cool adds full deadband.
module rsd_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cfg_abs_scheme,
	input wire rsd_pkg::rsd_ctrl_e cfg_ctrl,
	input wire logic cfg_two_level,
	input wire logic cfg_db_sym,
	input wire logic cfg_hc_via_obj,
	input wire logic cfg_overwrite,
	input wire logic cfg_base_bus_en,
	input wire logic cfg_step_coarse,
	input wire logic signed [15:0] cfg_base_temp,
	input wire logic [15:0] cfg_stby_red,
	input wire logic [15:0] cfg_night_red,
	input wire logic [15:0] cfg_stby_inc,
	input wire logic [15:0] cfg_night_inc,
	input wire logic [15:0] cfg_deadband,
	input wire logic [15:0] cfg_level_off,
	input wire logic signed [15:0] cfg_frost,
	input wire logic signed [15:0] cfg_heat_prot,
	input wire logic signed [15:0] cfg_abs_cmf_h,
	input wire logic signed [15:0] cfg_abs_stby_h,
	input wire logic signed [15:0] cfg_abs_night_h,
	input wire logic signed [15:0] cfg_abs_cmf_c,
	input wire logic signed [15:0] cfg_abs_stby_c,
	input wire logic signed [15:0] cfg_abs_night_c,
	input wire logic prog_load,
	input wire rsd_pkg::rsd_opmode_e op_mode,
	input wire logic hc_obj,
	input wire logic hc_auto_cool,
	input wire logic base_wr,
	input wire logic signed [15:0] base_wr_temp,
	input wire logic act_wr,
	input wire logic signed [15:0] act_wr_temp,
	output logic base_obj_present,
	output logic shift_avail,
	output logic signed [15:0] base_temp,
	output logic signed [15:0] sp_cmf_h,
	output logic signed [15:0] sp_stby_h,
	output logic signed [15:0] sp_night_h,
	output logic signed [15:0] sp_cmf_c,
	output logic signed [15:0] sp_stby_c,
	output logic signed [15:0] sp_night_c,
	output logic signed [15:0] sp_frost,
	output logic signed [15:0] sp_heat_prot,
	output logic hc_cooling,
	output logic signed [15:0] sp_active,
	output logic signed [15:0] sp_active_add,
	output logic wr_rejected
);
	localparam int TW = rsd_pkg::T_W;
	localparam int XW = rsd_pkg::CW;

	// ============================================================
	// Helpers
	function automatic logic signed [XW-1:0] sx(input logic signed [TW-1:0] v);
		sx = XW'(v);
	endfunction : sx

	function automatic logic signed [XW-1:0] ux(input logic [TW-1:0] v);
		ux = XW'(v);
	endfunction : ux

	function automatic logic signed [TW-1:0] lim(input logic signed [XW-1:0] v,
		input logic signed [XW-1:0] lo, input logic signed [XW-1:0] hi);
		if (v < lo) begin
			lim = TW'(lo);
		end else if (v > hi) begin
			lim = TW'(hi);
		end else begin
			lim = TW'(v);
		end
	endfunction : lim

	function automatic logic [2:0] abs_idx(input logic cool, input rsd_pkg::rsd_opmode_e m);
		logic [2:0] base;
		base = cool ? 3'(rsd_pkg::ABS_COOL_BASE) : 3'h0;
		case (m)
			rsd_pkg::RSD_STANDBY: abs_idx = base + 3'h1;
			rsd_pkg::RSD_NIGHT: abs_idx = base + 3'h2;
			default: abs_idx = base;
		endcase
	endfunction : abs_idx

	// ============================================================
	// Limits and protection values
	logic signed [XW-1:0] frost_x;
	logic signed [XW-1:0] hprot_x;
	logic signed [XW-1:0] rng_lo;
	logic signed [XW-1:0] rng_hi;
	logic signed [TW-1:0] base_rounded;
	logic signed [TW-1:0] cfg_abs [rsd_pkg::ABS_N];

	assign frost_x = sx(lim(sx(cfg_frost), rsd_pkg::TEMP_MIN, rsd_pkg::FROST_MAX));
	assign hprot_x = sx(lim(sx(cfg_heat_prot), rsd_pkg::TEMP_MIN, rsd_pkg::HPROT_MAX));
	assign cfg_abs[0] = cfg_abs_cmf_h;
	assign cfg_abs[1] = cfg_abs_stby_h;
	assign cfg_abs[2] = cfg_abs_night_h;
	assign cfg_abs[3] = cfg_abs_cmf_c;
	assign cfg_abs[4] = cfg_abs_stby_c;
	assign cfg_abs[5] = cfg_abs_night_c;

	always_comb begin
		case (cfg_ctrl)
			rsd_pkg::RSD_COOL_ONLY: begin
				rng_lo = rsd_pkg::COOL_MIN;
				rng_hi = (hprot_x < rsd_pkg::COOL_MAX) ? hprot_x : rsd_pkg::COOL_MAX;
			end
			rsd_pkg::RSD_HEAT_COOL: begin
				rng_lo = frost_x;
				rng_hi = hprot_x;
			end
			default: begin
				rng_lo = frost_x;
				rng_hi = rsd_pkg::HEAT_MAX;
			end
		endcase
	end

	rsd_round #(
		.W(TW)
	) u_round (
		.temp_in(base_wr_temp),
		.coarse(cfg_step_coarse),
		.temp_out(base_rounded)
	);

	// ============================================================
	// Stored setpoints
	logic signed [TW-1:0] base_reg;
	logic signed [TW-1:0] base_next;
	logic signed [TW-1:0] abs_reg [rsd_pkg::ABS_N];
	logic signed [TW-1:0] abs_next [rsd_pkg::ABS_N];
	logic rej_reg;
	logic rej_next;
	logic [2:0] act_idx;

	assign act_idx = abs_idx(hc_cooling, op_mode);

	always_comb begin
		base_next = base_reg;
		abs_next = abs_reg;
		rej_next = 1'b0;
		if (prog_load) begin
			if (cfg_overwrite) begin
				base_next = lim(sx(cfg_base_temp), rng_lo, rng_hi);
				for (int k = 0; k < rsd_pkg::ABS_N; k++) begin
					abs_next[k] = lim(sx(cfg_abs[k]), rsd_pkg::TEMP_MIN, rsd_pkg::ABS_MAX);
				end
			end
		end else begin
			if (base_wr) begin
				if (!cfg_abs_scheme && cfg_base_bus_en) begin
					base_next = lim(sx(base_rounded), rng_lo, rng_hi);
				end else begin
					rej_next = 1'b1;
				end
			end
			if (act_wr) begin
				if (cfg_abs_scheme && op_mode != rsd_pkg::RSD_PROTECT) begin
					abs_next[act_idx] = lim(sx(act_wr_temp), rsd_pkg::TEMP_MIN, rsd_pkg::ABS_MAX);
				end else begin
					rej_next = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			base_reg <= rsd_pkg::BASE_RST;
			for (int k = 0; k < rsd_pkg::ABS_N; k++) begin
				abs_reg[k] <= rsd_pkg::ABS_RST;
			end
			rej_reg <= 1'b0;
		end else begin
			base_reg <= base_next;
			abs_reg <= abs_next;
			rej_reg <= rej_next;
		end
	end

	// ============================================================
	// Derivation
	logic signed [XW-1:0] cmf_h_x;
	logic signed [XW-1:0] cmf_c_x;
	logic signed [XW-1:0] db_x;
	logic signed [TW-1:0] d_cmf_h;
	logic signed [TW-1:0] d_stby_h;
	logic signed [TW-1:0] d_night_h;
	logic signed [TW-1:0] d_cmf_c;
	logic signed [TW-1:0] d_stby_c;
	logic signed [TW-1:0] d_night_c;
	logic hc_cool_next;

	always_comb begin
		db_x = (cfg_ctrl == rsd_pkg::RSD_HEAT_COOL) ? ux(cfg_deadband) : '0;
		if (cfg_db_sym) begin
			cmf_h_x = sx(base_reg) - (db_x >>> 1);
			cmf_c_x = sx(base_reg) + (db_x >>> 1);
		end else begin
			cmf_h_x = sx(base_reg);
			cmf_c_x = sx(base_reg) + db_x;
		end
		d_cmf_h = lim(cmf_h_x, rng_lo, rng_hi);
		d_cmf_c = lim(cmf_c_x, rng_lo, rng_hi);
		d_stby_h = lim(sx(d_cmf_h) - ux(cfg_stby_red), rng_lo, sx(d_cmf_h));
		d_night_h = lim(sx(d_cmf_h) - ux(cfg_night_red), rng_lo, sx(d_cmf_h));
		d_stby_c = lim(sx(d_cmf_c) + ux(cfg_stby_inc), sx(d_cmf_c), rng_hi);
		d_night_c = lim(sx(d_cmf_c) + ux(cfg_night_inc), sx(d_cmf_c), rng_hi);
	end

	always_comb begin
		if (cfg_abs_scheme || cfg_hc_via_obj) begin
			hc_cool_next = hc_obj;
		end else begin
			case (cfg_ctrl)
				rsd_pkg::RSD_HEAT_ONLY: hc_cool_next = 1'b0;
				rsd_pkg::RSD_COOL_ONLY: hc_cool_next = 1'b1;
				default: hc_cool_next = hc_auto_cool;
			endcase
		end
	end

	// ============================================================
	// Output registers
	logic signed [TW-1:0] o_sp_next [rsd_pkg::ABS_N];
	logic signed [TW-1:0] o_sp_reg [rsd_pkg::ABS_N];
	logic signed [TW-1:0] act_next;
	logic signed [TW-1:0] act_add_next;
	logic signed [TW-1:0] act_reg;
	logic signed [TW-1:0] act_add_reg;
	logic signed [TW-1:0] frost_reg;
	logic signed [TW-1:0] hprot_reg;
	logic hc_reg;
	logic sel_cool;
	logic [2:0] sel_idx;
	logic signed [XW-1:0] lvl_x;

	always_comb begin
		if (cfg_abs_scheme) begin
			o_sp_next = abs_reg;
		end else begin
			o_sp_next[0] = d_cmf_h;
			o_sp_next[1] = d_stby_h;
			o_sp_next[2] = d_night_h;
			o_sp_next[3] = d_cmf_c;
			o_sp_next[4] = d_stby_c;
			o_sp_next[5] = d_night_c;
		end
		sel_cool = hc_cool_next;
		sel_idx = abs_idx(sel_cool, op_mode);
		if (op_mode == rsd_pkg::RSD_PROTECT) begin
			act_next = sel_cool ? TW'(hprot_x) : TW'(frost_x);
		end else begin
			act_next = o_sp_next[sel_idx];
		end
		lvl_x = cfg_two_level ? ux(cfg_level_off) : '0;
		if (sel_cool) begin
			act_add_next = lim(sx(act_next) + lvl_x, sx(act_next), rng_hi);
		end else begin
			act_add_next = lim(sx(act_next) - lvl_x, rng_lo, sx(act_next));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int k = 0; k < rsd_pkg::ABS_N; k++) begin
				o_sp_reg[k] <= rsd_pkg::ABS_RST;
			end
			act_reg <= rsd_pkg::ABS_RST;
			act_add_reg <= rsd_pkg::ABS_RST;
			frost_reg <= TW'(rsd_pkg::TEMP_MIN);
			hprot_reg <= TW'(rsd_pkg::TEMP_MIN);
			hc_reg <= 1'b0;
		end else begin
			o_sp_reg <= o_sp_next;
			act_reg <= act_next;
			act_add_reg <= act_add_next;
			frost_reg <= TW'(frost_x);
			hprot_reg <= TW'(hprot_x);
			hc_reg <= hc_cool_next;
		end
	end

	assign base_obj_present = cfg_base_bus_en && !cfg_abs_scheme;
	assign shift_avail = !cfg_abs_scheme;
	assign base_temp = base_reg;
	assign sp_cmf_h = o_sp_reg[0];
	assign sp_stby_h = o_sp_reg[1];
	assign sp_night_h = o_sp_reg[2];
	assign sp_cmf_c = o_sp_reg[3];
	assign sp_stby_c = o_sp_reg[4];
	assign sp_night_c = o_sp_reg[5];
	assign sp_frost = frost_reg;
	assign sp_heat_prot = hprot_reg;
	assign hc_cooling = hc_reg;
	assign sp_active = act_reg;
	assign sp_active_add = act_add_reg;
	assign wr_rejected = rej_reg;
endmodule : rsd_top

// ===== core/rsd_pkg.sv
// Purpose: Shared constants and types for room setpoint derivation
// Assumes: Temperatures are signed, in units of 0.1 degC
// Notes: Internal arithmetic is two bits wider than stored values
package rsd_pkg;
	localparam int T_W = 16;
	localparam int CW = 18;
	localparam int ABS_N = 6;
	localparam int ABS_COOL_BASE = 3;
	// Range limits, 0.1 degC
	localparam logic signed [17:0] TEMP_MIN = 18'sh00046;
	localparam logic signed [17:0] ABS_MAX = 18'sh00190;
	localparam logic signed [17:0] FROST_MAX = 18'sh00190;
	localparam logic signed [17:0] HPROT_MAX = 18'sh001c2;
	localparam logic signed [17:0] HEAT_MAX = 18'sh003e7;
	localparam logic signed [17:0] COOL_MIN = 18'sh3fc19;
	localparam logic signed [17:0] COOL_MAX = 18'sh001c2;
	// Rounding steps, 0.1 K
	localparam logic signed [17:0] STEP_COARSE = 18'sh00005;
	localparam logic signed [17:0] STEP_HALF = 18'sh00002;
	// Reset values
	localparam logic signed [15:0] BASE_RST = 16'sh00d2;
	localparam logic signed [15:0] ABS_RST = 16'sh00d2;
	typedef enum logic [1:0] {RSD_HEAT_ONLY, RSD_COOL_ONLY, RSD_HEAT_COOL} rsd_ctrl_e;
	typedef enum logic [1:0] {RSD_COMFORT, RSD_STANDBY, RSD_NIGHT, RSD_PROTECT} rsd_opmode_e;
endpackage : rsd_pkg

// ===== core/rsd_round.sv
// Purpose: Round a temperature to the shift step
// Assumes: Fine step is 0.1 K, the native unit
// Notes: Coarse step rounds half away from zero
module rsd_round #(
	parameter int W = 16
) (
	input wire logic signed [W-1:0] temp_in,
	input wire logic coarse,
	output logic signed [W-1:0] temp_out
);
	localparam int XW = rsd_pkg::CW;
	logic signed [rsd_pkg::CW-1:0] mag;
	logic signed [rsd_pkg::CW-1:0] q;

	// ============================================================
	// Rounding
	always_comb begin
		mag = temp_in[W-1] ? -XW'(temp_in) : XW'(temp_in);
		q = ((mag + rsd_pkg::STEP_HALF) / rsd_pkg::STEP_COARSE) * rsd_pkg::STEP_COARSE;
		if (!coarse) begin
			temp_out = temp_in;
		end else if (temp_in[W-1]) begin
			temp_out = W'(-q);
		end else begin
			temp_out = W'(q);
		end
	end
endmodule : rsd_round

// ===== bench/rsd_bus_dev.sv
// Purpose: Bus device sending 2-byte temperature telegrams
// Assumes: Driven on the falling edge of ref_clk
// Notes: Idle data shows the inverse of the last word
module rsd_bus_dev (
	input wire logic ref_clk,
	input wire logic req,
	input wire logic signed [15:0] req_temp,
	output logic wr,
	output logic signed [15:0] wr_temp
);
	timeunit 1ns;
	timeprecision 1ns;
	// ========
	// One-cycle telegram, one whole word
	initial begin
		wr = 1'b0;
		wr_temp = 16'h0000;
	end
	always @(negedge ref_clk) begin
		wr <= req;
		wr_temp <= req ? req_temp : (wr ? ~wr_temp : wr_temp);
	end
endmodule : rsd_bus_dev

// ===== bench/rsd_top_chk.sv
// Purpose: Port checks for setpoint derivation
// Assumes: One clock, synchronous reset
// Notes: Bound to rsd_top
module rsd_top_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cfg_abs_scheme,
	input wire logic cfg_base_bus_en,
	input wire logic cfg_step_coarse,
	input wire logic prog_load,
	input wire logic base_wr,
	input wire logic signed [15:0] base_wr_temp,
	input wire logic act_wr,
	input wire logic shift_avail,
	input wire logic signed [15:0] base_temp,
	input wire logic signed [15:0] sp_cmf_h,
	input wire logic signed [15:0] sp_stby_h,
	input wire logic signed [15:0] sp_night_h,
	input wire logic signed [15:0] sp_cmf_c,
	input wire logic signed [15:0] sp_stby_c,
	input wire logic signed [15:0] sp_night_c,
	input wire logic signed [15:0] sp_frost,
	input wire logic signed [15:0] sp_heat_prot,
	input wire logic wr_rejected
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// ========
	// Sequences
	sequence s_base_take;
		base_wr && !prog_load;
	endsequence
	sequence s_coarse_mid;
		s_base_take ##0 (cfg_step_coarse && cfg_base_bus_en && !cfg_abs_scheme && base_wr_temp >= 16'sh0064
			&& base_wr_temp <= 16'sh012c && sp_frost <= 16'sh0064 && sp_heat_prot >= 16'sh012c);
	endsequence
	// ========
	// Assertions
	a_base_refused: assert property (s_base_take ##0 (cfg_abs_scheme || !cfg_base_bus_en) |=> wr_rejected)
		else $error("reference write not refused");
	a_act_refused: assert property (act_wr && !prog_load && !cfg_abs_scheme |=> wr_rejected)
		else $error("active write not refused");
	a_idle_quiet: assert property (!base_wr && !act_wr |=> !wr_rejected)
		else $error("refusal without write");
	a_shift_gone: assert property (shift_avail == !cfg_abs_scheme)
		else $error("shift availability wrong");
	a_frost_range: assert property (sp_frost >= 16'sh0046 && sp_frost <= 16'sh0190)
		else $error("frost out of range");
	a_heat_order: assert property (!cfg_abs_scheme && !$past(cfg_abs_scheme)
		|-> sp_stby_h <= sp_cmf_h && sp_night_h <= sp_cmf_h)
		else $error("heat targets above comfort");
	a_cool_order: assert property (!cfg_abs_scheme && !$past(cfg_abs_scheme)
		|-> sp_stby_c >= sp_cmf_c && sp_night_c >= sp_cmf_c)
		else $error("cool targets below comfort");
	a_round_coarse: assert property (s_coarse_mid |=> base_temp % 16'sh0005 == 16'sh0000)
		else $error("reference not on coarse step");
endmodule : rsd_top_chk

bind rsd_top rsd_top_chk chk (.ref_clk, .rst, .cfg_abs_scheme, .cfg_base_bus_en, .cfg_step_coarse, .prog_load,
	.base_wr, .base_wr_temp, .act_wr, .shift_avail, .base_temp, .sp_cmf_h, .sp_stby_h, .sp_night_h, .sp_cmf_c,
	.sp_stby_c, .sp_night_c, .sp_frost, .sp_heat_prot, .wr_rejected);

// ===== bench/rsd_top_tb.sv
// Purpose: Self-checking bench for setpoint derivation
// Assumes: Inputs change on the falling edge
// Notes: Telegrams come from two bus device models
module rsd_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {rsd_pkg::rsd_ctrl_e c; logic s; logic signed [15:0] b; logic [95:0] e;} rsd_row_s;
	logic ref_clk, rst, cfg_abs_scheme, cfg_two_level, cfg_db_sym, cfg_hc_via_obj, cfg_overwrite, cfg_base_bus_en;
	logic cfg_step_coarse, prog_load, hc_obj, hc_auto_cool, base_req, act_req, base_wr, act_wr;
	rsd_pkg::rsd_ctrl_e cfg_ctrl;
	rsd_pkg::rsd_opmode_e op_mode;
	logic [15:0] cfg_stby_red, cfg_night_red, cfg_stby_inc, cfg_night_inc, cfg_deadband, cfg_level_off;
	logic signed [15:0] cfg_base_temp, cfg_frost, cfg_heat_prot, cfg_abs_cmf_h, cfg_abs_stby_h, cfg_abs_night_h;
	logic signed [15:0] cfg_abs_cmf_c, cfg_abs_stby_c, cfg_abs_night_c, base_wr_temp, act_wr_temp, req_temp;
	logic base_obj_present, shift_avail, hc_cooling, wr_rejected;
	logic signed [15:0] base_temp, sp_cmf_h, sp_stby_h, sp_night_h, sp_cmf_c, sp_stby_c, sp_night_c;
	logic signed [15:0] sp_frost, sp_heat_prot, sp_active, sp_active_add;
	wire [95:0] sp_all = {sp_cmf_h, sp_stby_h, sp_night_h, sp_cmf_c, sp_stby_c, sp_night_c};
	int mismatches, checks;
	rsd_row_s rows [5];
	rsd_top dut (.ref_clk, .rst, .cfg_abs_scheme, .cfg_ctrl, .cfg_two_level, .cfg_db_sym, .cfg_hc_via_obj,
		.cfg_overwrite, .cfg_base_bus_en, .cfg_step_coarse, .cfg_base_temp, .cfg_stby_red, .cfg_night_red,
		.cfg_stby_inc, .cfg_night_inc, .cfg_deadband, .cfg_level_off, .cfg_frost, .cfg_heat_prot, .cfg_abs_cmf_h,
		.cfg_abs_stby_h, .cfg_abs_night_h, .cfg_abs_cmf_c, .cfg_abs_stby_c, .cfg_abs_night_c, .prog_load, .op_mode,
		.hc_obj, .hc_auto_cool, .base_wr, .base_wr_temp, .act_wr, .act_wr_temp, .base_obj_present, .shift_avail,
		.base_temp, .sp_cmf_h, .sp_stby_h, .sp_night_h, .sp_cmf_c, .sp_stby_c, .sp_night_c, .sp_frost,
		.sp_heat_prot, .hc_cooling, .sp_active, .sp_active_add, .wr_rejected);
	rsd_bus_dev base_dev (.ref_clk, .req(base_req), .req_temp, .wr(base_wr), .wr_temp(base_wr_temp));
	rsd_bus_dev act_dev (.ref_clk, .req(act_req), .req_temp, .wr(act_wr), .wr_temp(act_wr_temp));
	// ========
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic prog();
		prog_load = 1'b1;
		cyc(1);
		prog_load = 1'b0;
		cyc(3);
	endtask : prog
	task automatic tel(input logic to_act, input logic signed [15:0] t);
		req_temp <= t;
		if (to_act) act_req <= 1'b1;
		else base_req <= 1'b1;
		cyc(1);
		act_req <= 1'b0;
		base_req <= 1'b0;
		cyc(1);
	endtask : tel
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// ========
	// Clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		summarize();
	end
	// ========
	// Stimulus
	initial begin
		rows = '{'{rsd_pkg::RSD_HEAT_ONLY, 1'b1, 16'sh00e6, 96'h00e6_00d2_00be_0000_0000_0000},
			'{rsd_pkg::RSD_COOL_ONLY, 1'b1, 16'sh00e6, 96'h0000_0000_0000_00e6_00fa_010e},
			'{rsd_pkg::RSD_HEAT_COOL, 1'b1, 16'sh00e6, 96'h00d7_00c3_00af_00f5_0109_011d},
			'{rsd_pkg::RSD_HEAT_COOL, 1'b0, 16'sh00e6, 96'h00e6_00d2_00be_0104_0118_012c},
			'{rsd_pkg::RSD_HEAT_ONLY, 1'b1, 16'sh0050, 96'h0050_0046_0046_0000_0000_0000}};
		{rst, cfg_two_level, cfg_db_sym, cfg_hc_via_obj, cfg_overwrite, cfg_base_bus_en} = 6'h3f;
		{cfg_abs_scheme, cfg_step_coarse, prog_load, hc_obj, hc_auto_cool, base_req, act_req} = 7'h00;
		{checks, mismatches} = '0;
		cfg_ctrl = rsd_pkg::RSD_HEAT_ONLY;
		op_mode = rsd_pkg::RSD_COMFORT;
		{cfg_stby_red, cfg_night_red, cfg_stby_inc, cfg_night_inc} = 64'h0014_0028_0014_0028;
		{cfg_deadband, cfg_level_off, cfg_base_temp, cfg_frost, cfg_heat_prot} = 80'h001e_000a_012c_0046_015e;
		{cfg_abs_cmf_h, cfg_abs_stby_h, cfg_abs_night_h} = 48'h00dc_00c8_00b4;
		{cfg_abs_cmf_c, cfg_abs_stby_c, cfg_abs_night_c, req_temp} = 64'h00f0_0104_0118_0000;
		cyc(16);
		rst = 1'b0;
		chk(base_temp, 16'sh00d2);
		chk(sp_frost, 16'sh0046);
		foreach (rows[i]) begin
			cfg_ctrl = rows[i].c;
			cfg_db_sym = rows[i].s;
			cfg_base_temp = rows[i].b;
			prog();
			for (int k = 0; k < 6; k++) begin
				if (k < 3 ? rows[i].c != rsd_pkg::RSD_COOL_ONLY : rows[i].c != rsd_pkg::RSD_HEAT_ONLY) begin
					chk(sp_all[95-16*k -: 16], rows[i].e[95-16*k -: 16]);
				end
			end
		end
		cfg_ctrl = rsd_pkg::RSD_HEAT_ONLY;
		cfg_base_temp = 16'sh00d2;
		prog();
		chk(sp_active, 16'sh00d2);
		chk(sp_active_add, 16'sh00c8);
		cfg_step_coarse = 1'b1;
		tel(1'b0, 16'sh00d5);
		chk(base_temp, 16'sh00d7);
		cyc(1);
		chk(sp_stby_h, 16'sh00c3);
		cfg_step_coarse = 1'b0;
		tel(1'b0, 16'sh00d5);
		chk(base_temp, 16'sh00d5);
		tel(1'b0, 16'sh0032);
		chk(base_temp, 16'sh0046);
		cfg_base_bus_en = 1'b0;
		tel(1'b0, 16'sh00fa);
		chk(16'({base_obj_present, wr_rejected}), 16'h0001);
		chk(base_temp, 16'sh0046);
		cfg_base_bus_en = 1'b1;
		tel(1'b1, 16'sh00fa);
		chk(16'(wr_rejected), 16'h0001);
		cfg_overwrite = 1'b0;
		cfg_base_temp = 16'sh012c;
		prog();
		chk(base_temp, 16'sh0046);
		cfg_overwrite = 1'b1;
		cfg_frost = 16'sh001e;
		cyc(2);
		chk(sp_frost, 16'sh0046);
		cfg_frost = 16'sh01f4;
		cyc(2);
		chk(sp_frost, 16'sh0190);
		cfg_frost = 16'sh0046;
		{cfg_abs_scheme, cfg_hc_via_obj, hc_auto_cool} = 3'h5;
		cfg_ctrl = rsd_pkg::RSD_HEAT_COOL;
		op_mode = rsd_pkg::RSD_STANDBY;
		prog();
		chk(sp_stby_h, 16'sh00c8);
		chk(16'({shift_avail, hc_cooling}), 16'h0000);
		tel(1'b1, 16'sh00e6);
		cyc(1);
		chk(sp_stby_h, 16'sh00e6);
		chk(sp_active, 16'sh00e6);
		chk(sp_stby_c, 16'sh0104);
		tel(1'b1, 16'sh01f4);
		cyc(1);
		chk(sp_stby_h, 16'sh0190);
		hc_obj = 1'b1;
		cyc(2);
		chk(16'(hc_cooling), 16'h0001);
		tel(1'b1, 16'sh003c);
		cyc(1);
		chk(sp_stby_c, 16'sh0046);
		op_mode = rsd_pkg::RSD_PROTECT;
		tel(1'b1, 16'sh00e6);
		chk(16'(wr_rejected), 16'h0001);
		cyc(1);
		chk(sp_active, 16'sh015e);
		chk(sp_heat_prot, 16'sh015e);
		tel(1'b0, 16'sh00e6);
		chk(16'(wr_rejected), 16'h0001);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		chk(base_temp, 16'sh00d2);
		chk(sp_heat_prot, 16'sh0046);
		chk(16'({hc_cooling, wr_rejected}), 16'h0000);
		cyc(1);
		chk(base_temp, 16'sh00d2);
		chk(sp_active, 16'sh015e);
		{cfg_abs_scheme, hc_obj} = 2'b00;
		cyc(2);
		chk(16'(hc_cooling), 16'h0001);
		summarize();
	end
endmodule : rsd_top_tb
